// *** design/crd_datapath.sv ***
/*
  crd_datapath: stack-machine cpu register datapath, steered by decoded
  microprogram field strobes. assumes the control store delivers one-hot
  strobes on this clock and the memory unit returns operands on mem_data_in.
*/
// Contract
// - stack memory pointer holds 16-bit address of topmost in-memory stack word.
// - scratch three shifts left, serial in at bit 0, out from bit 15.
// - tick counter is 16-bit, loadable and readable, advances each 1.001 ms.
// - tick counter advances only with interrupt-stack flag 0 and not halted.
// - tick counter wraps to zero after its maximum, about 65.6 s span.
// - next-skip code prefetches next instruction using code bank and counter.
// - operand register loads only when the operand-pending flip-flop fires.
// - frozen operand word goes to operand register and S-side register.
// - status bits: 0 privileged, 1 ext interrupts, 2 user traps, 3 op pending.
// - status bits 6:7 hold condition code 00 greater, 01 less, 10 equal.
// - status bits 8:15 hold the executing code segment number.
// - six-bit repeat counter loads negated count, increments and wraps past all ones, flagging all ones.
// - repeat counter captures stack occupancy on entry to halt mode.
// - overflow bit 4 captures alu overflow on enable, set and clear codes.
// - carry bit 5 captures alu carry on enable, set and clear codes.
// - pre-adder adds displacement to index for indexed non-indirect refs.
// - R-side register loads R-bus, shifts left; S-side loads S-bus, shifts right.
// - alu combines operands onto T-bus, shifter drives U-bus.
// - decimal mode adds 6 per digit with carries, overflow on bad digit.
// - address and data output buffers stage U-bus words to the data bus.
// - run cause register: sixteen cause bits, bit 10 zero, bit 15 option.
// - halt cause register: switch bits, bits 11,12 zero, bit 15 run flop.
// - three-bit occupancy counter increments on push, decrements on pop.
`timescale 1ns/1ps
`default_nettype none
module crd_datapath
  import crd_pkg::*;
#(
  parameter int TICK_CYC = CRD_TICK_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic [15:0]       r_bus_in,
  input  wire logic [15:0]       s_bus_in,
  input  wire logic              ld_r_in,
  input  wire logic              shl_r_in,
  input  wire logic              ld_s_in,
  input  wire logic              shr_s_in,
  input  wire crd_alu_op_t       alu_op_in,
  input  wire crd_shift_t        shift_in,
  input  wire logic              decimal_in,
  input  wire logic              st_sm_in,
  input  wire logic              st_sp3_in,
  input  wire logic              shr_sp3_in,
  input  wire logic              sp3_ser_in,
  input  wire logic              st_tick_in,
  input  wire logic              interrupt_stack_flag_in,
  input  wire logic              halted_in,
  input  wire logic              next_skip_in,
  input  wire logic [15:0]       code_base_ptr_in,
  input  wire logic [15:0]       prog_count_in,
  input  wire logic              operand_pending_ff_in,
  input  wire logic              frozen_in,
  input  wire logic [15:0]       mem_data_in,
  input  wire logic              st_flags_in,
  input  wire logic              set_cc_in,
  input  wire logic [1:0]        cc_in,
  input  wire logic              ovf_carry_capture_en_in,
  input  wire logic              set_overflow_code_in,
  input  wire logic              clear_overflow_code_in,
  input  wire logic              set_carry_code_in,
  input  wire logic              clear_carry_code_in,
  input  wire logic              st_repeat_counter_in,
  input  wire logic              inc_repeat_counter_in,
  input  wire logic              halt_entry_in,
  input  wire logic              push_in,
  input  wire logic              pop_in,
  input  wire logic [15:0]       current_instr_reg_in,
  input  wire logic [15:0]       index_in,
  input  wire logic              indexed_in,
  input  wire logic              st_addr_out_in,
  input  wire logic              st_data_out_in,
  input  wire logic [15:0]       run_causes_in,
  input  wire logic [15:0]       halt_causes_in,
  input  wire logic              clear_cause_code_in,
  output logic [15:0]            stack_mem_ptr_out,
  output logic [15:0]            scratch_three_out,
  output logic                   sp3_ser_out,
  output logic [15:0]            process_tick_counter_out,
  output logic                   prefetch_req_out,
  output logic [7:0]             prefetch_bank_out,
  output logic [15:0]            prefetch_addr_out,
  output logic [15:0]            operand_reg_out,
  output logic [15:0]            r_reg_out,
  output logic [15:0]            s_reg_out,
  output logic [15:0]            cpu_flags_word_out,
  output logic [5:0]             repeat_counter_out,
  output logic                   counter_max_test_out,
  output logic [2:0]             tos_count_out,
  output logic [15:0]            preadd_out,
  output logic [15:0]            u_bus_out,
  output logic [15:0]            address_out_reg_out,
  output logic [15:0]            data_out_reg_out,
  output logic [15:0]            run_interrupt_cause_out,
  output logic [15:0]            halt_interrupt_cause_out
);
  function automatic logic [4:0] bcd_digit(input logic [3:0] d, input logic ci);
    logic [4:0] s;
    s = {1'b0, d} + {4'h0, ci} + {1'b0, DEC_SIX};
    return s;
  endfunction

  logic [15:0] tick_next;
  logic [31:0] div_reg;
  logic        tick_en;
  logic [16:0] alu_sum;
  logic [15:0] t_bus;
  logic        alu_ovf;
  logic [15:0] dec_val;
  logic        dec_bad;
  logic [15:0] shifted;
  logic        ovf_in;
  logic [15:0] flags_next;
  logic [5:0]  repeat_counter_next;
  logic [2:0]  tos_next;

  // tick divider: counts only while running, so halts pause partial ticks too
  assign tick_en   = ~interrupt_stack_flag_in & ~halted_in;
  assign tick_next = st_tick_in ? s_bus_in
                   : (tick_en && div_reg == 32'(TICK_CYC - 1))
                     ? process_tick_counter_out + 16'h0001  // wraps
                     : process_tick_counter_out;

  always_comb begin
    alu_sum = 17'h0_0000;
    case (alu_op_in)
      CRD_ALU_ADD: alu_sum = {1'b0, r_reg_out} + {1'b0, s_reg_out};
      CRD_ALU_SUB: alu_sum = {1'b0, r_reg_out} + {1'b0, ~s_reg_out} + 17'h0_0001;
      CRD_ALU_AND: alu_sum = {1'b0, r_reg_out & s_reg_out};
      CRD_ALU_XOR: alu_sum = {1'b0, r_reg_out ^ s_reg_out};
      default:     alu_sum = 17'h0_0000;
    endcase
  end
  assign t_bus   = alu_sum[15:0];
  assign alu_ovf = (alu_op_in == CRD_ALU_ADD)
                   ? (r_reg_out[15] == s_reg_out[15]) && (t_bus[15] != r_reg_out[15])
                   : (alu_op_in == CRD_ALU_SUB)
                     ? (r_reg_out[15] != s_reg_out[15]) && (t_bus[15] != r_reg_out[15])
                     : 1'b0;

  // decimal corrector: digit chain, source digits checked for 0..9
  always_comb begin
    logic [4:0] d0;
    logic [4:0] d1;
    logic [4:0] d2;
    logic [4:0] d3;
    d0 = bcd_digit(t_bus[3:0], 1'b0);
    d1 = bcd_digit(t_bus[7:4], d0[4]);
    d2 = bcd_digit(t_bus[11:8], d1[4]);
    d3 = bcd_digit(t_bus[15:12], d2[4]);
    dec_val = {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
    dec_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (r_reg_out[i*4 +: 4] > DEC_NINE || s_reg_out[i*4 +: 4] > DEC_NINE) begin
        dec_bad = 1'b1;
      end
    end
  end

  always_comb begin
    shifted = t_bus;
    case (shift_in)
      CRD_SH_NONE:  shifted = t_bus;
      CRD_SH_LEFT:  shifted = {t_bus[14:0], 1'b0};
      CRD_SH_RIGHT: shifted = {1'b0, t_bus[15:1]};
      CRD_SH_SWAP:  shifted = {t_bus[7:0], t_bus[15:8]};
      default:      shifted = t_bus;
    endcase
  end
  // decimal mode bypasses the shifter entirely
  wire [15:0] u_bus = decimal_in ? dec_val : shifted;
  assign ovf_in = decimal_in ? dec_bad : alu_ovf;

  // status word; set codes win over clear codes, capture beats only the flags store
  always_comb begin
    flags_next = st_flags_in ? u_bus : cpu_flags_word_out;
    if (ovf_carry_capture_en_in) begin
      flags_next[STA_OVF_BIT] = ovf_in;
      flags_next[STA_CRY_BIT] = alu_sum[16];
    end
    if (clear_overflow_code_in) flags_next[STA_OVF_BIT] = 1'b0;
    if (set_overflow_code_in) flags_next[STA_OVF_BIT] = 1'b1;
    if (clear_carry_code_in) flags_next[STA_CRY_BIT] = 1'b0;
    if (set_carry_code_in) flags_next[STA_CRY_BIT] = 1'b1;
    if (set_cc_in) flags_next[STA_CC_LO +: 2] = cc_in;
  end

  assign tos_next  = tos_count_out + {2'b00, push_in & ~pop_in}
                     - {2'b00, pop_in & ~push_in};
  assign repeat_counter_next = halt_entry_in ? {3'b000, tos_count_out}
                   : st_repeat_counter_in ? u_bus[5:0]
                   : inc_repeat_counter_in ? repeat_counter_out + 6'h01
                   : repeat_counter_out;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      div_reg                  <= 32'h0000_0000;
      process_tick_counter_out <= REG_RESET;
      stack_mem_ptr_out        <= REG_RESET;
      scratch_three_out        <= REG_RESET;
      sp3_ser_out              <= 1'b0;
      prefetch_req_out         <= 1'b0;
      prefetch_bank_out        <= 8'h00;
      prefetch_addr_out        <= REG_RESET;
      operand_reg_out          <= REG_RESET;
      r_reg_out                <= REG_RESET;
      s_reg_out                <= REG_RESET;
      cpu_flags_word_out       <= STA_RESET;
      repeat_counter_out       <= REPEAT_COUNTER_RESET;
      counter_max_test_out     <= 1'b0;
      tos_count_out            <= 3'h0;
      preadd_out               <= REG_RESET;
      u_bus_out                <= REG_RESET;
      address_out_reg_out      <= REG_RESET;
      data_out_reg_out         <= REG_RESET;
      run_interrupt_cause_out  <= REG_RESET;
      halt_interrupt_cause_out <= REG_RESET;
    end else begin
      if (tick_en) begin
        div_reg <= (div_reg == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
      end
      process_tick_counter_out <= tick_next;
      if (st_sm_in) stack_mem_ptr_out <= u_bus;
      if (st_sp3_in) begin
        scratch_three_out <= u_bus;
      end else if (shr_sp3_in) begin
        scratch_three_out <= {scratch_three_out[14:0], sp3_ser_in};
        sp3_ser_out       <= scratch_three_out[15];
      end
      prefetch_req_out <= next_skip_in;
      if (next_skip_in) begin
        prefetch_bank_out <= code_base_ptr_in[7:0];
        prefetch_addr_out <= prog_count_in;
      end
      if (operand_pending_ff_in) operand_reg_out <= mem_data_in;
      if (ld_r_in) r_reg_out <= r_bus_in;
      else if (shl_r_in) r_reg_out <= {r_reg_out[14:0], 1'b0};
      if (frozen_in && operand_pending_ff_in) s_reg_out <= mem_data_in;
      else if (ld_s_in) s_reg_out <= s_bus_in;
      else if (shr_s_in) s_reg_out <= {1'b0, s_reg_out[15:1]};
      cpu_flags_word_out   <= flags_next;
      repeat_counter_out   <= repeat_counter_next;
      counter_max_test_out <= (repeat_counter_next == REPEAT_COUNTER_MAX);
      tos_count_out        <= tos_next;
      if (indexed_in) preadd_out <= index_in + {{8{current_instr_reg_in[7]}},
                                                current_instr_reg_in[7:0]};
      u_bus_out <= u_bus;
      if (st_addr_out_in) address_out_reg_out <= u_bus;
      if (st_data_out_in) data_out_reg_out <= u_bus;
      // causes are sticky; a new cause in the clear cycle still lands
      run_interrupt_cause_out <= ((clear_cause_code_in ? REG_RESET : run_interrupt_cause_out)
                                  | run_causes_in) & ~(16'h0001 << RUN_ZERO_BIT);
      halt_interrupt_cause_out <= (((clear_cause_code_in ? REG_RESET : halt_interrupt_cause_out)
                                   | halt_causes_in) & ~(16'h0001 << HALT_ZERO_LO)
                                   & ~(16'h0001 << HALT_ZERO_HI) & ~(16'h0001 << RUN_FF_BIT))
                                  | ({15'h0000, ~halted_in} << RUN_FF_BIT);
    end
  end

  a_tick_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!tick_en && !st_tick_in) |=> $stable(process_tick_counter_out))
    else $error("tick counter moved while stopped");
  a_operand_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
    operand_pending_ff_in |=> operand_reg_out == $past(mem_data_in))
    else $error("operand not captured");
  a_operand_frozen: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (frozen_in && operand_pending_ff_in) |=> s_reg_out == operand_reg_out)
    else $error("frozen operand not in s register");
  a_ovf_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    set_overflow_code_in |=> cpu_flags_word_out[STA_OVF_BIT])
    else $error("overflow not set");
  a_carry_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (clear_carry_code_in && !set_carry_code_in) |=> !cpu_flags_word_out[STA_CRY_BIT])
    else $error("carry not cleared");
  a_halt_count: assert property (@(posedge clk_in) disable iff (!nrst_in)
    halt_entry_in |=> repeat_counter_out == {3'b000, $past(tos_count_out)})
    else $error("halt count not saved");
  a_repeat_counter_max: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (inc_repeat_counter_in && !st_repeat_counter_in && !halt_entry_in && repeat_counter_out + 6'h01 == REPEAT_COUNTER_MAX)
    |=> counter_max_test_out)
    else $error("counter max flag wrong");
  a_tos_push: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (push_in && !pop_in) |=> tos_count_out == $past(tos_count_out) + 3'h1)
    else $error("push did not count");
  a_cause_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !run_interrupt_cause_out[RUN_ZERO_BIT] && !halt_interrupt_cause_out[HALT_ZERO_LO]
    && !halt_interrupt_cause_out[HALT_ZERO_HI])
    else $error("reserved cause bit set");
  a_sm_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !st_sm_in |=> $stable(stack_mem_ptr_out))
    else $error("stack pointer moved");
  c_tick_step: cover property (@(posedge clk_in) disable iff (!nrst_in)
    tick_en ##1 $changed(process_tick_counter_out));
  c_frozen: cover property (@(posedge clk_in) disable iff (!nrst_in)
    frozen_in && operand_pending_ff_in);
  c_decimal: cover property (@(posedge clk_in) disable iff (!nrst_in) decimal_in && dec_bad);
endmodule
`default_nettype wire

// *** design/crd_pkg.sv ***
/*
  crd_pkg: constants for the cpu register datapath.
  assumes a 20 MHz processor clock; field decoding happens upstream.
*/
package crd_pkg;
  localparam int          CRD_W          = 16;
  localparam int          CRD_REPEAT_COUNTER_W     = 6;
  localparam int          CRD_TOS_W      = 3;
  localparam int          CRD_CLK_NS     = 50;
  localparam int          CRD_TICK_NS    = 1001000;
  localparam int          CRD_TICK_CYC   = CRD_TICK_NS / CRD_CLK_NS;
  localparam int          STA_PRIV_BIT   = 0;
  localparam int          STA_EXTI_BIT   = 1;
  localparam int          STA_TRAP_BIT   = 2;
  localparam int          STA_OPB_BIT    = 3;
  localparam int          STA_OVF_BIT    = 4;
  localparam int          STA_CRY_BIT    = 5;
  localparam int          STA_CC_LO      = 6;
  localparam int          STA_SEG_LO     = 8;
  localparam logic [1:0]  CC_GREATER     = 2'h0;
  localparam logic [1:0]  CC_LESS        = 2'h1;
  localparam logic [1:0]  CC_EQUAL       = 2'h2;
  localparam logic [15:0] STA_RESET      = 16'h0000;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [5:0]  REPEAT_COUNTER_RESET     = 6'h00;
  localparam logic [5:0]  REPEAT_COUNTER_MAX       = 6'h3f;
  localparam logic [3:0]  DEC_SIX        = 4'h6;
  localparam logic [3:0]  DEC_NINE       = 4'h9;
  localparam int          RUN_ZERO_BIT   = 10;
  localparam int          HALT_ZERO_LO   = 11;
  localparam int          HALT_ZERO_HI   = 12;
  localparam int          OPTION_BIT     = 15;
  localparam int          RUN_FF_BIT     = 15;
  typedef enum logic [1:0] {CRD_ALU_ADD, CRD_ALU_SUB, CRD_ALU_AND, CRD_ALU_XOR} crd_alu_op_t;
  typedef enum logic [1:0] {CRD_SH_NONE, CRD_SH_LEFT, CRD_SH_RIGHT, CRD_SH_SWAP} crd_shift_t;
endpackage

// *** verif/cpu_register_datapath_test.sv ***
/*
  cpu_register_datapath_test: directed bench for crd_datapath.
  assumes the memory model answers operand reads; inputs change at negedge.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_register_datapath_test;
  import crd_pkg::*;
  localparam int TCK = 4;
  logic        clk_in = 1'b0;
  logic        nrst_in, ld_r_in, shl_r_in, ld_s_in, shr_s_in, decimal_in, st_sm_in, st_sp3_in;
  logic        shr_sp3_in, sp3_ser_in, st_tick_in, interrupt_stack_flag_in, halted_in;
  logic        next_skip_in, operand_pending_ff_in, frozen_in, st_flags_in, set_cc_in;
  logic        ovf_carry_capture_en_in, set_overflow_code_in, clear_overflow_code_in;
  logic        set_carry_code_in, clear_carry_code_in, st_repeat_counter_in, inc_repeat_counter_in, halt_entry_in;
  logic        push_in, pop_in, indexed_in, st_addr_out_in, st_data_out_in, clear_cause_code_in;
  logic        sp3_ser_out, prefetch_req_out, counter_max_test_out, rd_req, freeze;
  logic [1:0]  cc_in;
  logic [2:0]  tos_count_out;
  logic [5:0]  repeat_counter_out;
  logic [7:0]  prefetch_bank_out;
  logic [15:0] r_bus_in, s_bus_in, code_base_ptr_in, prog_count_in, mem_data_in, rd_word;
  logic [15:0] current_instr_reg_in, index_in, run_causes_in, halt_causes_in;
  logic [15:0] stack_mem_ptr_out, scratch_three_out, process_tick_counter_out, prefetch_addr_out;
  logic [15:0] operand_reg_out, r_reg_out, s_reg_out, cpu_flags_word_out, preadd_out, u_bus_out;
  logic [15:0] address_out_reg_out, data_out_reg_out;
  logic [15:0] run_interrupt_cause_out, halt_interrupt_cause_out;
  crd_alu_op_t alu_op_in;
  crd_shift_t  shift_in;
  int          error_cnt = 0;
  int          samples_checked = 0;

  crd_datapath #(.TICK_CYC(TCK)) DUT (.*);
  crd_mem_model u_mem (.clk_in(clk_in), .nrst_in(nrst_in), .rd_req_in(rd_req),
    .freeze_in(freeze), .rd_word_in(rd_word), .operand_pending_ff_out(operand_pending_ff_in),
    .frozen_out(frozen_in), .mem_data_out(mem_data_in));

  always #25 clk_in = ~clk_in;

  task automatic tick();
    @(negedge clk_in);
  endtask

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // load both operand registers; the u-bus then shows r op s
  task automatic ld_rs(input logic [15:0] r, input logic [15:0] s, input crd_alu_op_t op);
    r_bus_in = r;
    s_bus_in = s;
    alu_op_in = op;
    ld_r_in = 1'b1;
    ld_s_in = 1'b1;
    tick();
    ld_r_in = 1'b0;
    ld_s_in = 1'b0;
  endtask

  task automatic t_regs();
    ld_rs(16'h8001, 16'h8001, CRD_ALU_XOR);
    shl_r_in = 1'b1;
    shr_s_in = 1'b1;
    tick();
    shl_r_in = 1'b0;
    shr_s_in = 1'b0;
    cmp("r shift", 16'h0002, r_reg_out);
    cmp("s shift", 16'h4000, s_reg_out);
    st_sm_in = 1'b1;
    tick();
    st_sm_in = 1'b0;
    cmp("stack ptr", 16'h4002, stack_mem_ptr_out);
    ld_rs(16'h0010, 16'h0003, CRD_ALU_SUB);
    st_data_out_in = 1'b1;
    tick();
    st_data_out_in = 1'b0;
    cmp("data out", 16'h000d, data_out_reg_out);
    cmp("u bus", 16'h000d, u_bus_out);
    ld_rs(16'h8001, 16'h0000, CRD_ALU_ADD);
    st_addr_out_in = 1'b1;
    st_sp3_in = 1'b1;
    tick();
    {st_addr_out_in, st_sp3_in} = 2'b00;
    cmp("addr out", 16'h8001, address_out_reg_out);
    cmp("addr hold data", 16'h000d, data_out_reg_out);
    shr_sp3_in = 1'b1;
    sp3_ser_in = 1'b1;
    tick();
    cmp("sp3 shift1", 16'h0003, scratch_three_out);
    cmp("sp3 out1", 16'h0001, {15'h0, sp3_ser_out});
    sp3_ser_in = 1'b0;
    tick();
    shr_sp3_in = 1'b0;
    cmp("sp3 shift2", 16'h0006, scratch_three_out);
    cmp("sp3 out2", 16'h0000, {15'h0, sp3_ser_out});
    $display("test regs done");
  endtask

  task automatic t_flags();
    ld_rs(16'h1201, 16'h0000, CRD_ALU_ADD);
    st_flags_in = 1'b1;
    tick();
    st_flags_in = 1'b0;
    cmp("flags store", 16'h1201, cpu_flags_word_out);
    for (int i = 0; i < 3; i++) begin
      cc_in = 2'(i);
      set_cc_in = 1'b1;
      tick();
      set_cc_in = 1'b0;
      cmp("cond code", {8'h12, 2'(i), 6'h01}, cpu_flags_word_out);
    end
    set_overflow_code_in = 1'b1;
    tick();
    set_overflow_code_in = 1'b0;
    cmp("set ovf", 16'h1291, cpu_flags_word_out);
    clear_overflow_code_in = 1'b1;
    set_carry_code_in = 1'b1;
    tick();
    {clear_overflow_code_in, set_carry_code_in} = 2'b00;
    cmp("clr ovf set cry", 16'h12a1, cpu_flags_word_out);
    clear_carry_code_in = 1'b1;
    tick();
    clear_carry_code_in = 1'b0;
    cmp("clr cry", 16'h1281, cpu_flags_word_out);
    ld_rs(16'hffff, 16'h0001, CRD_ALU_ADD);
    ovf_carry_capture_en_in = 1'b1;
    tick();
    cmp("capture cry", 16'h12a1, cpu_flags_word_out);
    ld_rs(16'h7fff, 16'h0001, CRD_ALU_ADD);
    tick();
    ovf_carry_capture_en_in = 1'b0;
    cmp("capture ovf", 16'h1291, cpu_flags_word_out);
    $display("test flags done");
  endtask

  task automatic t_repeat_counter();
    ld_rs(16'h003d, 16'h0000, CRD_ALU_ADD);
    st_repeat_counter_in = 1'b1;
    tick();
    st_repeat_counter_in = 1'b0;
    for (int i = 0; i < 2; i++) begin
      inc_repeat_counter_in = 1'b1;
      tick();
      inc_repeat_counter_in = 1'b0;
      tick();
      cmp("repeat_counter", 16'(6'h3e + i), {10'h0, repeat_counter_out});
      cmp("repeat_counter max", 16'(i), {15'h0, counter_max_test_out});
    end
    push_in = 1'b1;
    repeat (3) tick();
    push_in = 1'b0;
    pop_in = 1'b1;
    tick();
    pop_in = 1'b0;
    cmp("tos count", 16'h0002, {13'h0, tos_count_out});
    halt_entry_in = 1'b1;
    tick();
    halt_entry_in = 1'b0;
    cmp("halt capture", 16'h0002, {10'h0, repeat_counter_out});
    $display("test repeat_counter done");
  endtask

  task automatic t_tick();
    int n;
    interrupt_stack_flag_in = 1'b1;
    s_bus_in = 16'hffff;
    st_tick_in = 1'b1;
    tick();
    st_tick_in = 1'b0;
    repeat (3 * TCK) tick();
    cmp("tick load ics", 16'hffff, process_tick_counter_out);
    interrupt_stack_flag_in = 1'b0;
    halted_in = 1'b1;
    repeat (3 * TCK) tick();
    cmp("tick halted", 16'hffff, process_tick_counter_out);
    cmp("run flop", 16'h0000, {15'h0, halt_interrupt_cause_out[15]});
    halted_in = 1'b0;
    n = 0;
    while (process_tick_counter_out === 16'hffff && n < 3 * TCK) begin
      tick();
      n++;
    end
    cmp("tick wrap", 16'h0000, process_tick_counter_out);
    n = 0;
    while (process_tick_counter_out === 16'h0000 && n < 3 * TCK) begin
      tick();
      n++;
    end
    cmp("tick interval", 16'(TCK), 16'(n));
    cmp("tick step", 16'h0001, process_tick_counter_out);
    $display("test tick done");
  endtask

  task automatic fetch(input logic [15:0] w, input logic fz);
    int n;
    rd_word = w;
    freeze = fz;
    rd_req = 1'b1;
    n = 0;
    while (operand_pending_ff_in !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    rd_req = 1'b0;
    tick();
  endtask

  task automatic t_operand_reg();
    ld_rs(16'h0000, 16'h1111, CRD_ALU_ADD);
    fetch(16'ha5c3, 1'b1);
    cmp("operand frozen", 16'ha5c3, operand_reg_out);
    cmp("s from operand", 16'ha5c3, s_reg_out);
    fetch(16'h5a3c, 1'b0);
    cmp("operand plain", 16'h5a3c, operand_reg_out);
    cmp("s kept", 16'ha5c3, s_reg_out);
    repeat (3) tick();
    cmp("operand idle", 16'h5a3c, operand_reg_out);
    $display("test operand_reg done");
  endtask

  task automatic t_misc();
    code_base_ptr_in = 16'h12ab;
    prog_count_in = 16'h4321;
    next_skip_in = 1'b1;
    tick();
    next_skip_in = 1'b0;
    cmp("prefetch req", 16'h0001, {15'h0, prefetch_req_out});
    cmp("prefetch bank", 16'h00ab, {8'h0, prefetch_bank_out});
    cmp("prefetch addr", 16'h4321, prefetch_addr_out);
    current_instr_reg_in = 16'h00fe;
    index_in = 16'h0010;
    indexed_in = 1'b1;
    tick();
    cmp("prefetch pulse", 16'h0000, {15'h0, prefetch_req_out});
    cmp("preadd", 16'h000e, preadd_out);
    run_causes_in = 16'hffff;
    halt_causes_in = 16'hffff;
    tick();
    cmp("run cause", 16'hfbff, run_interrupt_cause_out);
    cmp("halt cause", 16'he7ff, halt_interrupt_cause_out);
    run_causes_in = 16'h0000;
    halt_causes_in = 16'h0000;
    clear_cause_code_in = 1'b1;
    tick();
    clear_cause_code_in = 1'b0;
    cmp("run clear", 16'h0000, run_interrupt_cause_out);
    cmp("halt clear", 16'h8000, halt_interrupt_cause_out);
    $display("test misc done");
  endtask

  // decimal path must ignore the shifter; then left, right and swap shifts on an and result
  task automatic t_alu();
    ld_rs(16'h0045, 16'h0045, CRD_ALU_ADD);
    decimal_in = 1'b1;
    shift_in = CRD_SH_LEFT;
    ovf_carry_capture_en_in = 1'b1;
    tick();
    cmp("decimal sum", 16'h66f0, u_bus_out);
    cmp("decimal ovf", 16'h0000, {15'h0, cpu_flags_word_out[STA_OVF_BIT]});
    ld_rs(16'h000a, 16'h0000, CRD_ALU_ADD);
    tick();
    {decimal_in, ovf_carry_capture_en_in} = 2'b00;
    cmp("decimal bad", 16'h0001, {15'h0, cpu_flags_word_out[STA_OVF_BIT]});
    ld_rs(16'h12f4, 16'hff0f, CRD_ALU_AND);
    tick();
    cmp("and shl", 16'h2408, u_bus_out);
    shift_in = CRD_SH_RIGHT;
    tick();
    cmp("shr", 16'h0902, u_bus_out);
    shift_in = CRD_SH_SWAP;
    tick();
    cmp("swap", 16'h0412, u_bus_out);
    shift_in = CRD_SH_NONE;
    $display("test alu done");
  endtask

  initial begin
    {ld_r_in, shl_r_in, ld_s_in, shr_s_in, decimal_in, st_sm_in, st_sp3_in, shr_sp3_in} = '0;
    {sp3_ser_in, st_tick_in, interrupt_stack_flag_in, halted_in, next_skip_in} = '0;
    {st_flags_in, set_cc_in, ovf_carry_capture_en_in, set_overflow_code_in} = '0;
    {clear_overflow_code_in, set_carry_code_in, clear_carry_code_in, st_repeat_counter_in} = '0;
    {inc_repeat_counter_in, halt_entry_in, push_in, pop_in, indexed_in, st_addr_out_in} = '0;
    {st_data_out_in, clear_cause_code_in, rd_req, freeze, cc_in, nrst_in} = '0;
    {r_bus_in, s_bus_in, code_base_ptr_in, prog_count_in, rd_word} = '0;
    {current_instr_reg_in, index_in, run_causes_in, halt_causes_in} = '0;
    alu_op_in = CRD_ALU_ADD;
    shift_in = CRD_SH_NONE;
    repeat (12) tick();
    nrst_in = 1'b1;
    tick();
    cmp("reset flags", 16'h0000, cpu_flags_word_out);
    t_regs();
    t_flags();
    t_repeat_counter();
    t_tick();
    t_operand_reg();
    t_misc();
    t_alu();
    conclude();
  end

  // whole run is about a hundred cycles
  initial begin
    repeat (2000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire

// *** verif/crd_mem_model.sv ***
/*
  crd_mem_model: memory unit partner that answers operand reads.
  assumes the bench holds rd_req_in until the pending pulse is seen.
*/
`timescale 1ns/1ps
`default_nettype none
module crd_mem_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        rd_req_in,
  input  wire logic        freeze_in,
  input  wire logic [15:0] rd_word_in,
  output logic             operand_pending_ff_out,
  output logic             frozen_out,
  output logic [15:0]      mem_data_out
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wait_reg <= 2'h0;
      operand_pending_ff_out <= 1'b0;
      frozen_out <= 1'b0;
      mem_data_out <= 16'h0000;
    end else begin
      // one-cycle pending pulse carries the word
      operand_pending_ff_out <= (wait_reg == 2'h1);
      // released bus flips every cycle so stale data never looks valid
      mem_data_out <= (wait_reg == 2'h1) ? rd_word_in : ~mem_data_out;
      if (wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end else if (rd_req_in && !operand_pending_ff_out) begin
        wait_reg <= 2'h3;
      end
      // freeze spans the wait and the arriving word
      if (wait_reg == 2'h3) begin
        frozen_out <= freeze_in;
      end else if (operand_pending_ff_out) begin
        frozen_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
